/* common/rlf_pkg.sv */
// Constants, register map and types for the lane lock and frequency control slice
// Overview of operation
// - Ready flag set when frequency count latched
// - Idle power-down 100 ms after signal loss
// - Inhibit keeps lane powered after first detect
// - Recheck lock up to configured extra times
// - Lock regained during recheck clears counter
// - Taps two to five step limited
// - Tolerance scaled by two-bit selector
// - Capture bit cleared by hardware when done, unless software writes it in that cycle
// - First tap magnitude clamped to limit
`default_nettype none
package rlf_pkg;
  // Clock and idle power-down timing
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned IDLE_PD_MS = 100;
  localparam int unsigned IDLE_PD_CYC = IDLE_PD_MS * (CLK_HZ / 1000);
  // Register indices, byte address is four times the index
  localparam logic [7:0] IDX_LOCK_PWR = 8'h34;
  localparam logic [7:0] IDX_TOL_TAP1 = 8'h35;
  localparam logic [7:0] IDX_INT_REF = 8'h36;
  localparam logic [7:0] IDX_FREQ_LO = 8'h3b;
  localparam logic [7:0] IDX_FREQ_HI = 8'h3c;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h40;
  localparam logic [7:0] IDX_IRQ_CLR = 8'h41;
  localparam logic [7:0] IDX_IRQ_EN = 8'h42;
  localparam logic [7:0] IDX_LANE_STAT = 8'h43;
  // Field positions and widths
  localparam int BIT_FREQ_RDY = 7;
  localparam int BIT_PD_INH = 6;
  localparam int LOCK_CNT_LSB = 4;
  localparam int LOCK_CNT_W = 2;
  localparam int STEP_LSB = 0;
  localparam int STEP_W = 4;
  localparam int TOL_LSB = 6;
  localparam int TOL_W = 2;
  localparam int BIT_CAPT = 5;
  localparam int MAG_LSB = 0;
  localparam int MAG_W = 5;
  // Reset values and writable masks
  localparam logic [7:0] RST_LOCK_PWR = 8'h3f;
  localparam logic [7:0] RST_TOL_TAP1 = 8'h0f;
  localparam logic [7:0] RST_INT_REF = 8'h30;
  localparam logic [7:0] WMASK_LOCK_PWR = 8'h7f;
  localparam logic [7:0] WMASK_INT_REF = 8'h7f;
  // Interrupt sources
  localparam int IRQ_W = 3;
  localparam int IRQ_LOCK_LOSS = 0;
  localparam int IRQ_FREQ_RDY = 1;
  localparam int IRQ_PWR_DOWN = 2;
  // Equalizer and tolerance widths
  localparam int NTAPS = 5;
  localparam int TAP_W = 7;
  localparam int DELTA_W = 8;
  localparam int TOL_OUT_W = 10;
  localparam int FREQ_W = 16;
  // Tolerance selector codes
  localparam logic [1:0] TOL_X1 = 2'h0;
  localparam logic [1:0] TOL_X1_FRAC = 2'h1;
  localparam logic [1:0] TOL_X2 = 2'h2;
  localparam logic [1:0] TOL_X2_FRAC = 2'h3;

  typedef enum logic [1:0] {LK_UNLOCKED, LK_LOCKED, LK_RECHECK} rlf_lock_e;
endpackage
`default_nettype wire

/* core/rlf_tap_limiter.sv */
// Single equalizer tap limiter: step limit or magnitude clamp
`default_nettype none
module rlf_tap_limiter #(
  parameter int W = rlf_pkg::TAP_W,
  parameter bit USE_STEP = 1'b1
) (
  // Current and proposed tap
  input wire logic signed [W-1:0] cur,
  input wire logic signed [W-1:0] prop,
  // Limits
  input wire logic [rlf_pkg::STEP_W-1:0] step_lim,
  input wire logic [rlf_pkg::MAG_W-1:0] mag_lim,
  // Limited tap
  output logic signed [W-1:0] nxt
);
  logic signed [W:0] cur_x, prop_x, diff, lim, mag, sum;

  // Clamp the step or the magnitude
  always_comb begin
    cur_x = {cur[W-1], cur};
    prop_x = {prop[W-1], prop};
    diff = prop_x - cur_x;
    lim = signed'({{(W + 1 - rlf_pkg::STEP_W){1'b0}}, step_lim});
    mag = signed'({{(W + 1 - rlf_pkg::MAG_W){1'b0}}, mag_lim});
    sum = prop_x;
    if (USE_STEP) begin
      if (diff > lim) begin
        sum = cur_x + lim;
      end else if (diff < -lim) begin
        sum = cur_x - lim;
      end
    end else begin
      if (prop_x > mag) begin
        sum = mag;
      end else if (prop_x < -mag) begin
        sum = -mag;
      end
    end
    nxt = sum[W-1:0];
  end
endmodule
`default_nettype wire

/* core/rlf_lane_ctrl.sv */
// Lane lock, idle power and frequency control register slice with APB access
`default_nettype none
module rlf_lane_ctrl #(
  parameter int unsigned IDLE_PD_CYCLES = rlf_pkg::IDLE_PD_CYC,
  parameter int PADDR_W = 12
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  // Signal detect pin
  input wire logic sig_det,
  // Lock checker
  input wire logic lock_chk_stb,
  input wire logic lock_chk_ok,
  // Frequency counter
  input wire logic freq_valid,
  input wire logic [rlf_pkg::FREQ_W-1:0] freq_count,
  output logic freq_capture_req,
  // Tolerance
  input wire logic [rlf_pkg::DELTA_W-1:0] ppm_delta,
  output logic [rlf_pkg::TOL_OUT_W-1:0] freq_tol_scaled,
  // Equalizer adaptation
  input wire logic adapt_stb,
  input wire logic [rlf_pkg::NTAPS*rlf_pkg::TAP_W-1:0] tap_prop,
  output logic [rlf_pkg::NTAPS*rlf_pkg::TAP_W-1:0] tap_out,
  // Lane status
  output logic lane_power_on,
  output logic lane_locked
);
  typedef struct packed {
    logic [7:0] lock_pwr;
    logic [7:0] tol_tap1;
    logic [7:0] int_ref;
    logic [rlf_pkg::FREQ_W-1:0] freq_res;
    logic freq_rdy;
    logic [rlf_pkg::IRQ_W-1:0] irq_stat;
    logic [rlf_pkg::IRQ_W-1:0] irq_en;
    logic irq;
    rlf_pkg::rlf_lock_e lock_st;
    logic [rlf_pkg::LOCK_CNT_W-1:0] rchk;
    logic lock;
    logic sig_meta;
    logic sig_sync;
    logic seen_sig;
    logic pwr;
    logic [31:0] pd_cnt;
    logic [rlf_pkg::TOL_OUT_W-1:0] tol;
    logic [rlf_pkg::NTAPS-1:0][rlf_pkg::TAP_W-1:0] taps;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } rlf_state_s;

  localparam rlf_state_s RST = '{
    lock_pwr: rlf_pkg::RST_LOCK_PWR,
    tol_tap1: rlf_pkg::RST_TOL_TAP1,
    int_ref: rlf_pkg::RST_INT_REF,
    lock_st: rlf_pkg::LK_UNLOCKED,
    default: '0
  };

  rlf_state_s q, d;
  logic [rlf_pkg::NTAPS-1:0][rlf_pkg::TAP_W-1:0] lim_taps;
  logic [rlf_pkg::NTAPS-1:0][rlf_pkg::TAP_W-1:0] prop_taps;
  logic setup, acc, aligned, hit, wr, rd_hi, wr_tol;
  logic [7:0] idx;
  logic [7:0] rd;
  logic [rlf_pkg::IRQ_W-1:0] ev, clr;
  logic [rlf_pkg::LOCK_CNT_W-1:0] n_rchk;
  logic [rlf_pkg::DELTA_W-1:0] dl;
  logic [rlf_pkg::TOL_OUT_W-1:0] d1, d2, fr;

  assign prop_taps = tap_prop;

  // One limiter per tap, tap index zero is the first tap
  for (genvar i = 0; i < rlf_pkg::NTAPS; i++) begin : g_tap
    rlf_tap_limiter #(.W(rlf_pkg::TAP_W), .USE_STEP(i != 0)) u_lim (
      .cur(q.taps[i]),
      .prop(prop_taps[i]),
      .step_lim(q.lock_pwr[rlf_pkg::STEP_LSB +: rlf_pkg::STEP_W]),
      .mag_lim(q.tol_tap1[rlf_pkg::MAG_LSB +: rlf_pkg::MAG_W]),
      .nxt(lim_taps[i])
    );
  end

  // Next-state logic for the whole slice
  always_comb begin
    d = q;
    ev = '0;
    clr = '0;
    rd = 8'h00;
    hit = 1'b1;
    setup = psel & ~penable;
    acc = psel & penable & q.pready;
    idx = paddr[9:2];
    aligned = (paddr[1:0] == 2'h0) && (paddr[PADDR_W-1:10] == '0);
    // Address decode and read mux
    case (idx)
      rlf_pkg::IDX_LOCK_PWR: begin
        rd = {q.freq_rdy, q.lock_pwr[6:0]};
      end
      rlf_pkg::IDX_TOL_TAP1: rd = q.tol_tap1;
      rlf_pkg::IDX_INT_REF: rd = q.int_ref;
      rlf_pkg::IDX_FREQ_LO: rd = q.freq_res[7:0];
      rlf_pkg::IDX_FREQ_HI: rd = q.freq_res[15:8];
      rlf_pkg::IDX_IRQ_STAT: rd = 8'(q.irq_stat);
      rlf_pkg::IDX_IRQ_CLR: rd = 8'h00;
      rlf_pkg::IDX_IRQ_EN: rd = 8'(q.irq_en);
      rlf_pkg::IDX_LANE_STAT: rd = {5'h00, q.sig_sync, q.pwr, q.lock};
      default: hit = 1'b0;
    endcase
    hit = hit & aligned;
    wr = acc & pwrite & hit;
    wr_tol = wr && (idx == rlf_pkg::IDX_TOL_TAP1);
    rd_hi = acc & ~pwrite & hit && (idx == rlf_pkg::IDX_FREQ_HI);
    // Registered answer, one wait-free access phase
    d.pready = setup;
    d.prdata = setup ? {24'h000000, hit ? rd : 8'h00} : 32'h00000000;
    d.pslverr = setup & ~hit;
    // Software writes, reserved bits forced to zero
    if (wr) begin
      unique case (idx)
        rlf_pkg::IDX_LOCK_PWR: d.lock_pwr = pwdata[7:0] & rlf_pkg::WMASK_LOCK_PWR;
        rlf_pkg::IDX_TOL_TAP1: d.tol_tap1 = pwdata[7:0];
        rlf_pkg::IDX_INT_REF: d.int_ref = pwdata[7:0] & rlf_pkg::WMASK_INT_REF;
        rlf_pkg::IDX_IRQ_CLR: clr = pwdata[rlf_pkg::IRQ_W-1:0];
        rlf_pkg::IDX_IRQ_EN: d.irq_en = pwdata[rlf_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
    // Frequency result latch, capture bit cleared when done unless written in that cycle
    if (rd_hi) begin
      d.freq_rdy = 1'b0;
    end
    if (freq_valid) begin
      d.freq_res = freq_count;
      d.freq_rdy = 1'b1;
      ev[rlf_pkg::IRQ_FREQ_RDY] = 1'b1;
      if (!wr_tol) begin
        d.tol_tap1[rlf_pkg::BIT_CAPT] = 1'b0;
      end
    end
    // Signal detect synchroniser
    d.sig_meta = sig_det;
    d.sig_sync = q.sig_meta;
    // Idle power policy
    if (q.sig_sync) begin
      d.seen_sig = 1'b1;
      d.pwr = 1'b1;
      d.pd_cnt = '0;
    end else if (q.lock_pwr[rlf_pkg::BIT_PD_INH]) begin
      d.pwr = q.seen_sig;
      d.pd_cnt = '0;
    end else if (q.pwr) begin
      if (q.pd_cnt == 32'(IDLE_PD_CYCLES - 1)) begin
        d.pwr = 1'b0;
        d.pd_cnt = '0;
        ev[rlf_pkg::IRQ_PWR_DOWN] = 1'b1;
      end else begin
        d.pd_cnt = q.pd_cnt + 32'h00000001;
      end
    end
    // Lock monitor with rechecks
    n_rchk = q.lock_pwr[rlf_pkg::LOCK_CNT_LSB +: rlf_pkg::LOCK_CNT_W];
    if (lock_chk_stb) begin
      unique case (q.lock_st)
        rlf_pkg::LK_UNLOCKED: begin
          if (lock_chk_ok) begin
            d.lock_st = rlf_pkg::LK_LOCKED;
            d.lock = 1'b1;
          end
        end
        rlf_pkg::LK_LOCKED: begin
          d.rchk = '0;
          if (!lock_chk_ok && n_rchk == '0) begin
            d.lock_st = rlf_pkg::LK_UNLOCKED;
            d.lock = 1'b0;
            ev[rlf_pkg::IRQ_LOCK_LOSS] = 1'b1;
          end else if (!lock_chk_ok) begin
            d.lock_st = rlf_pkg::LK_RECHECK;
          end
        end
        rlf_pkg::LK_RECHECK: begin
          if (lock_chk_ok) begin
            d.lock_st = rlf_pkg::LK_LOCKED;
            d.rchk = '0;
          end else if (2'(q.rchk + 2'h1) >= n_rchk) begin
            d.lock_st = rlf_pkg::LK_UNLOCKED;
            d.lock = 1'b0;
            d.rchk = '0;
            ev[rlf_pkg::IRQ_LOCK_LOSS] = 1'b1;
          end else begin
            d.rchk = 2'(q.rchk + 2'h1);
          end
        end
      endcase
    end
    // Tolerance scaling
    dl = ppm_delta;
    d1 = {2'b00, dl};
    d2 = {1'b0, dl, 1'b0};
    fr = {7'h00, dl[3:1]};
    unique case (q.tol_tap1[rlf_pkg::TOL_LSB +: rlf_pkg::TOL_W])
      rlf_pkg::TOL_X1: d.tol = d1;
      rlf_pkg::TOL_X1_FRAC: d.tol = d1 + fr;
      rlf_pkg::TOL_X2: d.tol = d2;
      rlf_pkg::TOL_X2_FRAC: d.tol = d2 + fr;
    endcase
    // Adaptation step applies the limited taps
    if (adapt_stb) begin
      d.taps = lim_taps;
    end
    // Sticky status, set wins over clear
    d.irq_stat = (q.irq_stat & ~clr) | ev;
    d.irq = |(d.irq_stat & d.irq_en);
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from flops
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign irq = q.irq;
  assign freq_capture_req = q.tol_tap1[rlf_pkg::BIT_CAPT];
  assign freq_tol_scaled = q.tol;
  assign tap_out = q.taps;
  assign lane_power_on = q.pwr;
  assign lane_locked = q.lock;

  // Assertions
  function automatic int tap_abs(input logic signed [rlf_pkg::TAP_W-1:0] v);
    return (v < 0) ? -int'(v) : int'(v);
  endfunction

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_rdy_set;
    freq_valid |=> q.freq_rdy && q.freq_res == $past(freq_count);
  endproperty
  a_rdy_set: assert property (p_rdy_set) else $error("ready flag not set");

  property p_pd_time;
    $fell(q.pwr) |-> $past(q.pd_cnt) == 32'(IDLE_PD_CYCLES - 1) && !$past(q.sig_sync);
  endproperty
  a_pd_time: assert property (p_pd_time) else $error("power down early");

  property p_inh_keep;
    q.lock_pwr[rlf_pkg::BIT_PD_INH] && q.pwr ##1 q.lock_pwr[rlf_pkg::BIT_PD_INH] |-> q.pwr;
  endproperty
  a_inh_keep: assert property (p_inh_keep) else $error("inhibit lost power");

  property p_sig_on;
    q.sig_sync |=> q.pwr ##1 q.pwr or !q.sig_sync;
  endproperty
  a_sig_on: assert property (p_sig_on) else $error("no power on detect");

  property p_lock_hold;
    q.lock_st == rlf_pkg::LK_LOCKED && lock_chk_stb && !lock_chk_ok &&
      n_rchk != '0 |=> q.lock && q.lock_st == rlf_pkg::LK_RECHECK;
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lock dropped early");

  property p_lock_drop;
    q.lock_st == rlf_pkg::LK_RECHECK && lock_chk_stb && !lock_chk_ok &&
      2'(q.rchk + 2'h1) == n_rchk |=> !q.lock ##1 !q.lock || $past(lock_chk_stb);
  endproperty
  a_lock_drop: assert property (p_lock_drop) else $error("lock not dropped");

  property p_regain;
    q.lock_st == rlf_pkg::LK_RECHECK && lock_chk_stb && lock_chk_ok |=> q.lock && q.rchk == '0;
  endproperty
  a_regain: assert property (p_regain) else $error("recheck not reset");

  property p_step;
    adapt_stb |=> tap_abs(q.taps[1] - $past(q.taps[1])) <=
      int'($past(q.lock_pwr[rlf_pkg::STEP_LSB +: rlf_pkg::STEP_W]));
  endproperty
  a_step: assert property (p_step) else $error("tap step too large");

  property p_tol_x2;
    q.tol_tap1[rlf_pkg::TOL_LSB +: rlf_pkg::TOL_W] == rlf_pkg::TOL_X2 |=>
      q.tol == {1'b0, $past(ppm_delta), 1'b0};
  endproperty
  a_tol_x2: assert property (p_tol_x2) else $error("tolerance scale wrong");

  property p_capt_clr;
    freq_valid && !wr_tol |=> !q.tol_tap1[rlf_pkg::BIT_CAPT];
  endproperty
  a_capt_clr: assert property (p_capt_clr) else $error("capture not cleared");

  property p_tap1;
    adapt_stb |=> tap_abs(q.taps[0]) <=
      int'($past(q.tol_tap1[rlf_pkg::MAG_LSB +: rlf_pkg::MAG_W]));
  endproperty
  a_tap1: assert property (p_tap1) else $error("first tap over limit");

  property p_rsvd;
    q.prdata[31:8] == '0 && (q.int_ref & ~rlf_pkg::WMASK_INT_REF) == 8'h00;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits nonzero");

  c_lock_loss: cover property (q.lock_st == rlf_pkg::LK_RECHECK ##[1:200] !q.lock);
  c_pwr_down: cover property ($fell(q.pwr));
  c_capture: cover property (wr_tol && pwdata[rlf_pkg::BIT_CAPT] ##[1:200] freq_valid);
endmodule
`default_nettype wire

/* bench/rlf_far_model.sv */
// Far-side stand-in: signal detect, lock checker and frequency counter
`default_nettype none
module rlf_far_model (
  // Clock
  input wire logic pclk,
  // Lane inputs driven here
  output logic sig_det,
  output logic lock_chk_stb,
  output logic lock_chk_ok,
  output logic freq_valid,
  output logic [rlf_pkg::FREQ_W-1:0] freq_count
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle levels at time zero
  initial begin
    sig_det = 1'b0;
    lock_chk_stb = 1'b0;
    lock_chk_ok = 1'b0;
    freq_valid = 1'b0;
    freq_count = 16'h0000;
  end
  // One lock check result as a single pulse
  task automatic check(input logic ok);
    @(posedge pclk);
    lock_chk_stb <= 1'b1;
    lock_chk_ok <= ok;
    @(posedge pclk);
    lock_chk_stb <= 1'b0;
    lock_chk_ok <= ~ok; // Stale result not held
    repeat (2) @(posedge pclk);
    @(negedge pclk);
  endtask
  // One new frequency-error count
  task automatic freq(input logic [15:0] c);
    @(posedge pclk);
    freq_valid <= 1'b1;
    freq_count <= c;
    @(posedge pclk);
    freq_valid <= 1'b0;
    freq_count <= ~c; // Count not held after pulse
    repeat (2) @(posedge pclk);
    @(negedge pclk);
  endtask
  // Signal detect level change, then settle
  task automatic sig(input logic s);
    @(posedge pclk);
    sig_det <= s;
    repeat (4) @(posedge pclk);
    @(negedge pclk);
  endtask
endmodule
`default_nettype wire

/* bench/tb.sv */
// Self-checking bench for the lane lock and frequency control slice
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PD = 20;
  logic pclk, presetn, psel, penable, pwrite, irq, pready, pslverr, adapt_stb;
  logic sig_det, lock_chk_stb, lock_chk_ok, freq_valid, freq_capture_req;
  logic lane_power_on, lane_locked, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, v;
  logic [15:0] freq_count;
  logic [7:0] ppm_delta;
  logic [9:0] freq_tol_scaled;
  logic [34:0] tap_prop, tap_out;
  integer seed = 32'h8b7cc9e5;
  int failures = 0;
  int check_count = 0;
  int e, p, m, st;
  int cur[5];
  // Design and far side
  rlf_lane_ctrl #(.IDLE_PD_CYCLES(PD), .PADDR_W(12)) rlf_lane_ctrl_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .sig_det(sig_det), .lock_chk_stb(lock_chk_stb), .lock_chk_ok(lock_chk_ok),
    .freq_valid(freq_valid), .freq_count(freq_count), .freq_capture_req(freq_capture_req),
    .ppm_delta(ppm_delta), .freq_tol_scaled(freq_tol_scaled), .adapt_stb(adapt_stb),
    .tap_prop(tap_prop), .tap_out(tap_out), .lane_power_on(lane_power_on),
    .lane_locked(lane_locked));
  rlf_far_model rlf_far_model_i (.pclk(pclk), .sig_det(sig_det), .lock_chk_stb(lock_chk_stb),
    .lock_chk_ok(lock_chk_ok), .freq_valid(freq_valid), .freq_count(freq_count));
  // Clock, 40 ns period
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // One APB transfer, result left in rd and err
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Access phase held until pready is seen at a rising edge
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) failures++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask
  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    apb(1'b1, {2'b00, i, 2'b00}, d);
  endtask
  task automatic rdc(input logic [7:0] i, input logic [31:0] x);
    apb(1'b0, {2'b00, i, 2'b00}, 32'h0);
    chk(rd, x);
    chk(32'(err), 32'h0);
  endtask
  // Hang guard
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    give_verdict();
  end
  // Main sequence
  initial begin
    {psel, penable, pwrite, adapt_stb, presetn} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    ppm_delta = 8'h00;
    tap_prop = 35'h0;
    cur = '{default: 0};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, reserved bit, unmapped place
    rdc(8'h34, 32'h3f);
    rdc(8'h35, 32'h0f);
    rdc(8'h36, 32'h30);
    wr(8'h36, 32'hffffffff);
    rdc(8'h36, 32'h7f);
    apb(1'b0, 12'h0dc, 32'h0);
    chk(32'(err), 32'h1);
    // Misaligned and out-of-range addresses refused, write dropped
    apb(1'b1, 12'h0d9, 32'h0);
    chk(32'(err), 32'h1);
    apb(1'b1, 12'h4d8, 32'h0);
    chk(32'(err), 32'h1);
    rdc(8'h36, 32'h7f);
    // Capture, ready flag, result bytes, interrupt
    wr(8'h42, 32'h2);
    wr(8'h35, 32'h2f);
    chk(32'(freq_capture_req), 32'h1);
    v = $random(seed);
    rlf_far_model_i.freq(v[15:0]);
    chk(32'(irq), 32'h1);
    rdc(8'h35, 32'h0f);
    rdc(8'h34, 32'hbf);
    rdc(8'h3b, {24'h0, v[7:0]});
    rdc(8'h3c, {24'h0, v[15:8]});
    rdc(8'h34, 32'h3f);
    wr(8'h41, 32'h2);
    chk(32'(irq), 32'h0);
    wr(8'h42, 32'h0);
    rlf_far_model_i.freq(v[31:16]);
    chk(32'(irq), 32'h0);
    rdc(8'h40, 32'h2);
    // Tolerance scaling, every selector code
    for (int s = 0; s < 4; s++) begin
      v = $random(seed);
      wr(8'h35, {24'h0, s[1:0], 6'h0f});
      @(posedge pclk);
      ppm_delta <= v[7:0];
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      e = (int'(v[7:0]) << s[1]) + (s[0] ? int'(v[3:1]) : 0);
      chk(32'(freq_tol_scaled), e);
    end
    // Lock recheck for every count
    for (int n = 0; n < 4; n++) begin
      wr(8'h34, {24'h0, 2'b00, n[1:0], 4'hf});
      rlf_far_model_i.check(1'b1);
      repeat (n) rlf_far_model_i.check(1'b0);
      rlf_far_model_i.check(1'b1);
      repeat (n) rlf_far_model_i.check(1'b0);
      chk(32'(lane_locked), 32'h1);
      rlf_far_model_i.check(1'b0);
      chk(32'(lane_locked), 32'h0);
    end
    // Idle power-down, then inhibit
    rdc(8'h40, 32'h3);
    wr(8'h41, 32'h7);
    wr(8'h34, 32'h3f);
    rlf_far_model_i.sig(1'b1);
    chk(32'(lane_power_on), 32'h1);
    rlf_far_model_i.sig(1'b0);
    repeat (PD / 2) @(posedge pclk);
    @(negedge pclk);
    chk(32'(lane_power_on), 32'h1);
    repeat (PD) @(posedge pclk);
    rdc(8'h40, 32'h4);
    chk(32'(lane_power_on), 32'h0);
    wr(8'h34, 32'h7f);
    rlf_far_model_i.sig(1'b1);
    rlf_far_model_i.sig(1'b0);
    repeat (2 * PD) @(posedge pclk);
    @(negedge pclk);
    chk(32'(lane_power_on), 32'h1);
    rdc(8'h43, 32'h2);
    // Equalizer tap limits with random limits and proposals
    for (int k = 0; k < 8; k++) begin
      v = $random(seed);
      st = v[3:0];
      m = v[8:4];
      wr(8'h34, {24'h0, 4'h3, v[3:0]});
      wr(8'h35, {24'h0, 3'h0, v[8:4]});
      @(posedge pclk);
      tap_prop <= 35'({$random(seed), $random(seed)});
      adapt_stb <= 1'b1;
      @(posedge pclk);
      adapt_stb <= 1'b0;
      @(negedge pclk);
      for (int i = 0; i < 5; i++) begin
        p = int'($signed(tap_prop[i*7 +: 7]));
        if (i == 0) e = (p > m) ? m : (p < -m) ? -m : p;
        else e = (p > cur[i] + st) ? cur[i] + st : (p < cur[i] - st) ? cur[i] - st : p;
        chk(32'(tap_out[i*7 +: 7]), 32'(e[6:0]));
        cur[i] = e;
      end
    end
    give_verdict();
  end
endmodule
`default_nettype wire
